// file: src/fpx_ops_unit.sv
// Extra floating-point ops unit: constants, NaN min/max, rounding,
// modular convert and wide register moves, one cycle from issue.
// Assumes the core gates issue, reads operands and writes back results.
`timescale 1ns/1ps
module fpx_ops_unit
  import fpx_pkg::*;
#(
  parameter int XLEN = 32,
  parameter bit HAS_F = 1'b1,
  parameter bit HAS_D = 1'b1,
  parameter bit HAS_H = 1'b1,
  parameter bit HAS_Q = 1'b0
) (
  input logic ref_clk,
  input logic sys_rst,
  input logic issueValid,
  input logic [6:0] opcode,
  input logic [6:0] funct7,
  input logic [2:0] funct3,
  input logic [4:0] rs1Idx,
  input logic [4:0] rs2Idx,
  input logic [4:0] rdIdx,
  input logic [2:0] frm,
  input logic [FPW-1:0] fpA,
  input logic [FPW-1:0] fpB,
  input logic [XLEN-1:0] intA,
  input logic [XLEN-1:0] intB,
  output logic doneValid,
  output logic fpWe,
  output logic intWe,
  output logic [4:0] rdOut,
  output logic [FPW-1:0] fpResult,
  output logic [XLEN-1:0] intResult,
  output logic [4:0] fflags,
  output logic illegalInsn
);

  ////////////////////////////////////////////////////////////////
  // Helper functions

  // Format present in this build; nothing exists without single
  function automatic logic fpx_fmt_ok(logic [1:0] f);
    case (f)
      FMT_S: return HAS_F;
      FMT_D: return HAS_F && HAS_D;
      FMT_H: return HAS_F && HAS_H;
      default: return HAS_F && HAS_D && HAS_Q;
    endcase
  endfunction

  // Ordered less-than on sign and magnitude, minus zero below plus zero
  function automatic logic fpx_less(logic [FPW-1:0] a, logic [FPW-1:0] b,
                                    logic [1:0] f);
    logic [FPW-1:0] m;
    logic sa;
    logic sb;
    m = fpx_mask(fpx_exp_w(f) + fpx_man_w(f));
    sa = a[fpx_exp_w(f) + fpx_man_w(f)];
    sb = b[fpx_exp_w(f) + fpx_man_w(f)];
    if (sa != sb) begin
      return sa;
    end else if (sa) begin
      return (a & m) > (b & m);
    end else begin
      return (a & m) < (b & m);
    end
  endfunction

  // Expand a table entry into the chosen format
  function automatic logic [FPW-1:0] fpx_const(logic [4:0] idx, logic [1:0] f);
    logic [10:0] t;
    logic [FPW-1:0] ex;
    logic [FPW-1:0] mn;
    int ew;
    int mw;
    t = FPX_CONST_TBL[idx];
    ew = fpx_exp_w(f);
    mw = fpx_man_w(f);
    mn = FPW'(t[1:0]) << (mw - 2); // Two top bits only
    if ((&t[9:2]) || (f == FMT_H && idx == LDC_IDX_HINF)) begin
      // Infinity and NaN; half has no room for two to the sixteenth
      ex = fpx_mask(ew);
    end else if (idx == LDC_IDX_MIN) begin
      // Least normal of whichever format
      ex = FPW'(1);
    end else if (f == FMT_H && (idx == LDC_IDX_H2 || idx == LDC_IDX_H3)) begin
      // Subnormal in half, below entry 1
      ex = '0;
      mn = FPW'(2'(idx[1:0] - 2'h1)) << (mw - 2);
    end else begin
      // Rebias the single exponent
      ex = FPW'(int'(t[9:2]) - SGL_BIAS + ((1 << (ew - 1)) - 1));
    end
    return fpx_box((FPW'(t[10]) << (ew + mw)) | (ex << mw) | mn, f);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Field decode

  wire [1:0] fmt = funct7[1:0]; // Format in low funct7 bits
  wire [2:0] rmEff = (funct3 == RM_DYN) ? frm : funct3;
  wire isOpFp = opcode == OPC_OP_FP;

  // Constant load sits beside the integer-to-float move
  wire hitLdc = isOpFp && funct7[6:2] == F7_LDC && rs2Idx == RS2_LDC &&
                funct3 == F3_MOVE;

  // Min/max with bit 13 set, that is funct3 bit 1
  wire hitMm = isOpFp && funct7[6:2] == F7_MINMAX &&
               (funct3 == F3_MINM || funct3 == F3_MAXM);

  // Rounding beside the float-to-float converts
  wire hitRnd = isOpFp && funct7[6:2] == F7_CVT_FF &&
                (rs2Idx == RS2_RND || rs2Idx == RS2_RNDX);

  // Modular convert beside double-to-word
  wire hitMod = isOpFp && funct7 == F7_CVT_WD && rs2Idx == RS2_MOD;

  // High-half moves
  wire hitMvh = isOpFp && funct3 == F3_MOVE && rs2Idx == RS2_MVH &&
                (funct7 == F7_MVH_D || funct7 == F7_MVH_Q);

  // Pair moves, rs2 names a register here
  wire hitMvp = isOpFp && funct3 == F3_MOVE &&
                (funct7 == F7_MVP_D || funct7 == F7_MVP_Q);

  ////////////////////////////////////////////////////////////////
  // Legality per operation

  wire fmtOk = fpx_fmt_ok(fmt);
  wire rmOk = rmEff <= RM_RMM; // Codes five and six are reserved
  wire okRnd = fmtOk && rmOk;
  // Only an explicit toward-zero code is allowed
  wire okMod = fpx_fmt_ok(FMT_D) && funct3 == RM_RTZ;
  wire wideOk = (funct7 == F7_MVH_D || funct7 == F7_MVP_D) ?
                (XLEN == 32 && fpx_fmt_ok(FMT_D)) :
                (XLEN == 64 && fpx_fmt_ok(FMT_Q));
  wire anyHit = hitLdc || hitMm || hitRnd || hitMod || hitMvh || hitMvp;

  // Chosen operation; priority is moot since encodings do not overlap
  wire fpx_op_t decOp = !issueValid ? OP_NONE :
                        (hitLdc && fmtOk) ? OP_LDC :
                        (hitMm && fmtOk) ? OP_MINMAX :
                        (hitRnd && okRnd) ? OP_RND :
                        (hitMod && okMod) ? OP_MOD :
                        (hitMvh && wideOk) ? OP_MVH :
                        (hitMvp && wideOk) ? OP_MVP : OP_NONE;

  // Recognised but not allowed here
  wire next_illegal = issueValid && anyHit && decOp == OP_NONE;

  ////////////////////////////////////////////////////////////////
  // Constant load and min/max

  wire [FPW-1:0] ldcRes = fpx_const(rs1Idx, fmt);
  wire aNan = fpx_is_nan(fpA, fmt);
  wire bNan = fpx_is_nan(fpB, fmt);
  wire aSnan = aNan && !fpA[fpx_man_w(fmt) - 1];
  wire bSnan = bNan && !fpB[fpx_man_w(fmt) - 1];
  // Ties keep the second operand for min, the first for max
  wire mmPickA = (funct3 == F3_MINM) == fpx_less(fpA, fpB, fmt);
  // Any NaN wins outright
  wire [FPW-1:0] mmRes = (aNan || bNan) ? fpx_canon(fmt) :
                         fpx_box(mmPickA ? fpA : fpB, fmt);

  ////////////////////////////////////////////////////////////////
  // One rounding slice per format; unused slices cost area
  // but keep the select a plain mux instead of a shared shifter

  logic [FPW-1:0] rndRes [4];
  logic [3:0] rndNv;
  logic [3:0] rndNx;
  for (genvar g = 0; g < 4; g++) begin : g_rnd
    localparam int EW = fpx_exp_w(2'(g));
    localparam int MW = fpx_man_w(2'(g));
    logic [EW+MW:0] r;
    fpx_round #(.EW(EW), .MW(MW)) u_rnd (
      .val(fpA[EW+MW:0]),
      .rm(rmEff),
      .exactMode(rs2Idx == RS2_RNDX),
      .res(r),
      .nvOut(rndNv[g]),
      .nxOut(rndNx[g])
    );
    assign rndRes[g] = fpx_box(FPW'(r), 2'(g));
  end

  ////////////////////////////////////////////////////////////////
  // Modular double-to-word convert

  logic [MOD_BITS-1:0] modW;
  logic modNv;
  logic modNx;
  wire modSpecial = &fpA[62:52]; // Infinity or NaN
  // Truncate, keep low word, flags as the bounded convert
  always_comb begin
    int ue;
    logic [63:0] sig;
    logic [63:0] mag;
    logic [63:0] lost;
    logic inRange;
    ue = int'(fpA[62:52]) - DBL_BIAS;
    sig = {11'h000, fpA[62:52] != 11'h000, fpA[51:0]};
    mag = '0;
    lost = '0;
    inRange = 1'b0;
    if (ue < 0) begin
      lost = sig; // Zero leaves nothing lost
    end else if (ue <= DBL_MAN_W) begin
      mag = sig >> (DBL_MAN_W - ue);
      lost = sig & ((64'h1 << (DBL_MAN_W - ue)) - 64'h1);
    end else begin
      mag = sig << (ue - DBL_MAN_W); // Big shifts drop to zero
    end
    // Truncation toward zero keeps minus two to the 31 in range
    inRange = !modSpecial && (ue < MOD_BITS - 1 || (ue == MOD_BITS - 1 &&
              fpA[63] && mag == 64'h0000_0000_8000_0000));
    modNv = !inRange;
    modNx = inRange && lost != '0;
    if (modSpecial) begin
      modW = '0;
    end else if (fpA[63]) begin
      modW = ~mag[MOD_BITS-1:0] + 32'h1;
    end else begin
      modW = mag[MOD_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register moves

  wire [63:0] intA64 = 64'(intA);
  wire [63:0] intB64 = 64'(intB);
  wire [FPW-1:0] mvhWide = (funct7 == F7_MVH_D) ? {96'h0, fpA[63:32]} :
                           {64'h0, fpA[127:64]};
  wire [FPW-1:0] mvpRes = (funct7 == F7_MVP_D) ?
                          fpx_box({64'h0, intB64[31:0], intA64[31:0]}, FMT_D) :
                          {intB64, intA64};

  ////////////////////////////////////////////////////////////////
  // Result select

  logic [FPW-1:0] next_fp;
  logic [XLEN-1:0] next_int;
  logic [4:0] next_flags;
  logic next_fpWe;
  logic next_intWe;

  always_comb begin
    next_fp = '0;
    next_int = '0;
    next_flags = '0; // Constant loads and moves keep this clear
    next_fpWe = 1'b0;
    next_intWe = 1'b0;
    case (decOp)
      OP_LDC: begin
        next_fp = ldcRes;
        next_fpWe = 1'b1;
      end
      OP_MINMAX: begin
        next_fp = mmRes;
        next_flags[FLG_NV] = aSnan || bSnan;
        next_fpWe = 1'b1;
      end
      OP_RND: begin
        next_fp = rndRes[fmt];
        next_flags[FLG_NV] = rndNv[fmt];
        next_flags[FLG_NX] = rndNx[fmt];
        next_fpWe = 1'b1;
      end
      OP_MOD: begin
        next_int = XLEN'($signed(modW)); // Sign extended
        next_flags[FLG_NV] = modNv;
        next_flags[FLG_NX] = modNx;
        next_intWe = 1'b1;
      end
      OP_MVH: begin
        next_int = mvhWide[XLEN-1:0];
        next_intWe = 1'b1;
      end
      OP_MVP: begin
        next_fp = mvpRes;
        next_fpWe = 1'b1;
      end
      default: begin
        next_fp = '0; // Nothing issued, nothing written
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Output registers, one cycle after issue

  fpx_op_t opReg; // Operation in the output stage

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      doneValid <= 1'b0;
      fpWe <= 1'b0;
      intWe <= 1'b0;
      rdOut <= '0;
      fpResult <= '0;
      intResult <= '0;
      fflags <= '0;
      illegalInsn <= 1'b0;
      opReg <= OP_NONE;
    end else begin
      doneValid <= decOp != OP_NONE;
      fpWe <= next_fpWe;
      intWe <= next_intWe;
      rdOut <= rdIdx;
      fpResult <= next_fp;
      intResult <= next_int;
      fflags <= next_flags;
      illegalInsn <= next_illegal;
      opReg <= decOp;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ldc_single;
    issueValid && hitLdc && fmtOk && fmt == FMT_S;
  endsequence

  sequence s_rnd_plain;
    decOp == OP_RND && rs2Idx == RS2_RND;
  endsequence

  sequence s_mod_special;
    decOp == OP_MOD && modSpecial;
  endsequence

  a_ldc_decode_write: assert property (
    issueValid && hitLdc && fmtOk |=> doneValid && fpWe && !intWe)
    else $error("constant load not written");

  a_ldc_single_value: assert property (
    s_ldc_single |=> fpResult[31:21] == FPX_CONST_TBL[$past(rs1Idx)])
    else $error("single constant wrong");

  a_ldc_low_mant: assert property (
    s_ldc_single |=> fpResult[20:0] == '0 && fpResult[127:32] == '1)
    else $error("constant low mantissa set");

  a_ldc_half_inf: assert property (
    issueValid && hitLdc && fmtOk && fmt == FMT_H && rs1Idx == LDC_IDX_HINF
    |=> fpResult[15:0] == 16'h7c00)
    else $error("half entry 29 not infinity");

  a_ldc_no_flags: assert property (
    doneValid && opReg == OP_LDC |-> fflags == '0)
    else $error("constant load raised a flag");

  a_minmax_nan: assert property (
    decOp == OP_MINMAX && (aNan || bNan)
    |=> fpResult == fpx_canon($past(fmt)))
    else $error("min/max NaN not canonical");

  a_round_plain_flags: assert property (
    s_rnd_plain |=> fflags[3:0] == '0 && doneValid)
    else $error("plain round raised extra flag");

  a_mod_special_zero: assert property (
    s_mod_special |=> intResult == '0 && fflags[FLG_NV] && intWe)
    else $error("modular convert special not zero");

  a_mod_rm_reserved: assert property (
    issueValid && hitMod && funct3 != RM_RTZ |=> illegalInsn && !doneValid)
    else $error("reserved rm accepted");

  a_mvh_high_copy: assert property (
    decOp == OP_MVH && funct7 == F7_MVH_D
    |=> intResult[31:0] == $past(fpA[63:32]) && intWe)
    else $error("double high half wrong");

  a_mvp_pair_join: assert property (
    decOp == OP_MVP && funct7 == F7_MVP_D
    |=> fpResult[63:0] == {$past(intB64[31:0]), $past(intA64[31:0])})
    else $error("pair move wrong");

  a_base_needed: assert property (
    issueValid && (hitLdc || hitMm || hitRnd) && !fmtOk |=> illegalInsn && !fpWe && !intWe)
    else $error("op accepted without format support");
endmodule

// file: src/fpx_pkg.sv
// Constants, op codes and format helpers of the extra floating-point ops unit.
// Assumes the core splits the instruction word and checks NaN-boxing itself.
// Behaviour
// - Constant load picks entry by rs1, rs2=1
// - Table fixes sign, exponent, significand per entry
// - Constants set only two top mantissa bits
// - Double constant load uses double encoding
// - Quad constant load uses quad encoding
// - Half entry 29 gives positive infinity
// - Half entries 2 and 3 are subnormal
// - Constant loads never raise any flag
// - Any NaN min/max operand gives canonical NaN
// - Min/max variants decoded with bit 13 set
// - Round to integral by rm, same format
// - Plain round flags invalid on signaling NaN
// - Exact round also flags inexact results
// - Single round decoded with rs2 4, 5
// - Other formats round decoded rs2 4, 5
// - Modular convert truncates, keeps low 32, extends
// - Infinity and NaN convert to zero
// - Modular convert flags match word convert
// - Modular convert needs double, rm toward zero
// - 32-bit base: double high half to integer
// - 32-bit base: integer pair to double
// - 64-bit base: quad high half to integer
// - 64-bit base: integer pair to quad
// - All ops need single-precision support
package fpx_pkg;
  localparam int FPW = 128; // Widest register, narrower values boxed
  localparam logic [6:0] OPC_OP_FP = 7'h53;
  localparam logic [4:0] F7_LDC = 5'h1e; // Upper five funct7 bits
  localparam logic [4:0] F7_MINMAX = 5'h05;
  localparam logic [4:0] F7_CVT_FF = 5'h08;
  localparam logic [6:0] F7_CVT_WD = 7'h61;
  localparam logic [6:0] F7_MVH_D = 7'h71;
  localparam logic [6:0] F7_MVH_Q = 7'h73;
  localparam logic [6:0] F7_MVP_D = 7'h59;
  localparam logic [6:0] F7_MVP_Q = 7'h5b;
  localparam logic [4:0] RS2_LDC = 5'h01;
  localparam logic [4:0] RS2_RND = 5'h04;
  localparam logic [4:0] RS2_RNDX = 5'h05;
  localparam logic [4:0] RS2_MOD = 5'h08;
  localparam logic [4:0] RS2_MVH = 5'h01;
  localparam logic [2:0] F3_MOVE = 3'h0;
  localparam logic [2:0] F3_MINM = 3'h2;
  localparam logic [2:0] F3_MAXM = 3'h3;
  localparam logic [2:0] RM_RNE = 3'h0;
  localparam logic [2:0] RM_RTZ = 3'h1;
  localparam logic [2:0] RM_RDN = 3'h2;
  localparam logic [2:0] RM_RUP = 3'h3;
  localparam logic [2:0] RM_RMM = 3'h4;
  localparam logic [2:0] RM_DYN = 3'h7;
  localparam logic [1:0] FMT_S = 2'h0;
  localparam logic [1:0] FMT_D = 2'h1;
  localparam logic [1:0] FMT_H = 2'h2;
  localparam logic [1:0] FMT_Q = 2'h3;
  localparam int FLG_NV = 4; // Flag order NV DZ OF UF NX
  localparam int FLG_NX = 0;
  localparam int SGL_BIAS = 127;
  localparam int DBL_BIAS = 1023;
  localparam int DBL_MAN_W = 52;
  localparam int MOD_BITS = 32;
  localparam logic [4:0] LDC_IDX_MIN = 5'h01;
  localparam logic [4:0] LDC_IDX_HINF = 5'h1d;
  localparam logic [4:0] LDC_IDX_H2 = 5'h02;
  localparam logic [4:0] LDC_IDX_H3 = 5'h03;
  // Constant table as {sign, single exponent, two top mantissa bits}
  localparam logic [10:0] FPX_CONST_TBL [32] = '{
    11'h5fc, 11'h004, 11'h1bc, 11'h1c0, 11'h1dc, 11'h1e0, 11'h1ec, 11'h1f0,
    11'h1f4, 11'h1f5, 11'h1f6, 11'h1f7, 11'h1f8, 11'h1f9, 11'h1fa, 11'h1fb,
    11'h1fc, 11'h1fd, 11'h1fe, 11'h1ff, 11'h200, 11'h201, 11'h202, 11'h204,
    11'h208, 11'h20c, 11'h218, 11'h21c, 11'h238, 11'h23c, 11'h3fc, 11'h3fe};

  // Operations this unit executes
  typedef enum logic [2:0] {
    OP_NONE, OP_LDC, OP_MINMAX, OP_RND, OP_MOD, OP_MVH, OP_MVP
  } fpx_op_t;

  function automatic int fpx_exp_w(logic [1:0] f);
    case (f)
      FMT_S: return 8;
      FMT_D: return 11;
      FMT_H: return 5;
      default: return 15;
    endcase
  endfunction

  function automatic int fpx_man_w(logic [1:0] f);
    case (f)
      FMT_S: return 23;
      FMT_D: return 52;
      FMT_H: return 10;
      default: return 112;
    endcase
  endfunction

  function automatic logic [FPW-1:0] fpx_mask(int n);
    return (n >= FPW) ? '1 : ((FPW'(1) << n) - FPW'(1));
  endfunction

  // Keep the format's bits, fill everything above with ones
  function automatic logic [FPW-1:0] fpx_box(logic [FPW-1:0] v, logic [1:0] f);
    logic [FPW-1:0] m;
    m = fpx_mask(1 + fpx_exp_w(f) + fpx_man_w(f));
    return (v & m) | ~m;
  endfunction

  function automatic logic [FPW-1:0] fpx_canon(logic [1:0] f);
    return fpx_box((fpx_mask(fpx_exp_w(f)) << fpx_man_w(f)) |
                   (FPW'(1) << (fpx_man_w(f) - 1)), f);
  endfunction

  function automatic logic fpx_is_nan(logic [FPW-1:0] v, logic [1:0] f);
    logic [FPW-1:0] e;
    e = (v >> fpx_man_w(f)) & fpx_mask(fpx_exp_w(f));
    return (e == fpx_mask(fpx_exp_w(f))) && ((v & fpx_mask(fpx_man_w(f))) != '0);
  endfunction
endpackage

// file: src/fpx_round.sv
// Round-to-integral datapath for one format, purely combinational.
// Assumes the caller registers the result and picks the format.
`timescale 1ns/1ps
module fpx_round
  import fpx_pkg::*;
#(
  parameter int EW = 8,
  parameter int MW = 23
) (
  input logic [EW+MW:0] val,
  input logic [2:0] rm,
  input logic exactMode,
  output logic [EW+MW:0] res,
  output logic nvOut,
  output logic nxOut
);
  localparam int BIAS = (1 << (EW - 1)) - 1;

  ////////////////////////////////////////////////////////////////
  // Field split and classification
  wire sgn = val[EW+MW];
  wire [EW-1:0] ex = val[EW+MW-1:MW];
  wire [MW-1:0] man = val[MW-1:0];
  wire isNanIn = (&ex) && (man != '0);
  wire isZero = (ex == '0) && (man == '0);
  wire signed [EW+1:0] unb = $signed({2'b00, ex}) - $signed((EW + 2)'(BIAS));
  wire tiny = unb < 0; // Below one, result is zero or one
  wire whole = unb >= MW; // Already integral, also infinity
  wire [MW+1:0] sig = {2'b01, man};

  ////////////////////////////////////////////////////////////////
  // Guard, sticky and increment, then the rounded value
  always_comb begin
    int fw;
    logic [MW+1:0] mask;
    logic [MW+1:0] half;
    logic [MW+1:0] sum;
    logic rb;
    logic st;
    logic lsb;
    logic inc;
    fw = MW - int'(unb);
    mask = '0;
    half = '0;
    rb = 1'b0;
    st = 1'b0;
    lsb = 1'b0;
    inc = 1'b0;
    sum = '0;
    if (tiny) begin
      // Only exponent -1 can reach the half point
      rb = (unb == -1);
      st = rb ? (man != '0) : !isZero;
    end else if (!whole) begin
      mask = ((MW + 2)'(1) << fw) - (MW + 2)'(1);
      half = (MW + 2)'(1) << (fw - 1);
      rb = |(sig & half);
      st = |(sig & (mask >> 1));
      lsb = |(sig & (half << 1));
    end
    case (rm)
      RM_RNE: inc = rb && (st || lsb);
      RM_RDN: inc = sgn && (rb || st);
      RM_RUP: inc = !sgn && (rb || st);
      RM_RMM: inc = rb;
      default: inc = 1'b0;
    endcase
    sum = (sig & ~mask) + (inc ? (half << 1) : '0);
    res = val; // Zero and infinity pass unchanged
    nvOut = 1'b0;
    nxOut = 1'b0;
    if (isNanIn) begin
      res = {1'b0, {EW{1'b1}}, 1'b1, {(MW - 1){1'b0}}};
      nvOut = !man[MW-1]; // Signaling NaN only
    end else if (!(isZero || whole)) begin
      nxOut = exactMode && (rb || st);
      if (tiny) begin
        res = inc ? {sgn, EW'(BIAS), MW'(0)} : {sgn, (EW + MW)'(0)};
      end else if (sum[MW+1]) begin
        res = {sgn, ex + EW'(1), MW'(0)};
      end else begin
        res = {sgn, ex, sum[MW-1:0]};
      end
    end
  end
endmodule

// file: test/fpx_core_model.sv
// Core-side model: fp register file and accrued flags behind the unit.
// Assumes results arrive as one-cycle write pulses from the unit.
`timescale 1ns/1ps
module fpx_core_model
  import fpx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic doneValid,
  input wire logic fpWe,
  input wire logic [4:0] rdOut,
  input wire logic [FPW-1:0] fpResult,
  input wire logic [4:0] fflags,
  output logic [4:0] accrued
);
  logic [FPW-1:0] fpRegs [32]; // Fp register file
  // Accrue only; clearing is left to software, as in a real core
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      accrued <= 5'h00;
    end else if (doneValid) begin
      accrued <= accrued | fflags;
      if (fpWe) begin
        fpRegs[rdOut] <= fpResult;
      end
    end
  end
endmodule

// file: test/fp_extra_ops_unit_tb_top.sv
// Testbench of the extra fp ops unit: table of issues, then idle and reset.
// Assumes default parameters: 32-bit base with single, double and half.
`timescale 1ns/1ps
module fp_extra_ops_unit_tb_top
  import fpx_pkg::*;
;
  typedef struct packed {
    logic [6:0] f7; logic [2:0] f3; logic [4:0] s1; logic [4:0] s2;
    logic [63:0] a; logic [63:0] b; logic [63:0] e; logic [4:0] fl; logic [1:0] w;
  } fpx_row_t; // w: 0 illegal, 1 fp write, 2 int write
  localparam int NR = 29;
  localparam fpx_row_t ROWS [NR] = '{
    '{7'h78,3'h0,5'h10,5'h01,64'h0,64'h0,64'hffffffff3f800000,5'h00,2'h1},
    '{7'h78,3'h0,5'h00,5'h01,64'h0,64'h0,64'hffffffffbf800000,5'h00,2'h1},
    '{7'h78,3'h0,5'h1f,5'h01,64'h0,64'h0,64'hffffffff7fc00000,5'h00,2'h1},
    '{7'h78,3'h0,5'h1e,5'h01,64'h0,64'h0,64'hffffffff7f800000,5'h00,2'h1},
    '{7'h79,3'h0,5'h01,5'h01,64'h0,64'h0,64'h0010000000000000,5'h00,2'h1},
    '{7'h79,3'h0,5'h09,5'h01,64'h0,64'h0,64'h3fd4000000000000,5'h00,2'h1},
    '{7'h7a,3'h0,5'h1d,5'h01,64'h0,64'h0,64'hffffffffffff7c00,5'h00,2'h1},
    '{7'h7a,3'h0,5'h02,5'h01,64'h0,64'h0,64'hffffffffffff0100,5'h00,2'h1},
    '{7'h7a,3'h0,5'h03,5'h01,64'h0,64'h0,64'hffffffffffff0200,5'h00,2'h1},
    '{7'h14,3'h2,5'h01,5'h02,64'h3f800000,64'h7fc00001,64'hffffffff7fc00000,5'h00,2'h1},
    '{7'h14,3'h3,5'h01,5'h02,64'h3f800000,64'h40000000,64'hffffffff40000000,5'h00,2'h1},
    '{7'h15,3'h2,5'h01,5'h02,64'h3ff0000000000000,64'h7ff0000000000001,
      64'h7ff8000000000000,5'h10,2'h1},
    '{7'h20,3'h0,5'h01,5'h04,64'h40200000,64'h0,64'hffffffff40000000,5'h00,2'h1},
    '{7'h20,3'h0,5'h01,5'h05,64'h40200000,64'h0,64'hffffffff40000000,5'h01,2'h1},
    '{7'h20,3'h0,5'h01,5'h04,64'h7f800001,64'h0,64'hffffffff7fc00000,5'h10,2'h1},
    '{7'h20,3'h0,5'h01,5'h05,64'h7f800000,64'h0,64'hffffffff7f800000,5'h00,2'h1},
    '{7'h21,3'h3,5'h01,5'h04,64'h3ff8000000000000,64'h0,64'h4000000000000000,5'h00,2'h1},
    '{7'h22,3'h1,5'h01,5'h05,64'h3e00,64'h0,64'hffffffffffff3c00,5'h01,2'h1},
    '{7'h61,3'h1,5'h01,5'h08,64'h41f0000000500000,64'h0,64'h5,5'h10,2'h2},
    '{7'h61,3'h1,5'h01,5'h08,64'hbff8000000000000,64'h0,64'hffffffff,5'h01,2'h2},
    '{7'h61,3'h1,5'h01,5'h08,64'h7ff0000000000000,64'h0,64'h0,5'h10,2'h2},
    '{7'h61,3'h0,5'h01,5'h08,64'h3ff0000000000000,64'h0,64'h0,5'h00,2'h0},
    '{7'h71,3'h0,5'h01,5'h01,64'h1234567889abcdef,64'h0,64'h12345678,5'h00,2'h2},
    '{7'h59,3'h0,5'h01,5'h02,64'h1234567889abcdef,64'h0,64'h1234567889abcdef,5'h00,2'h1},
    '{7'h7b,3'h0,5'h01,5'h01,64'h0,64'h0,64'h0,5'h00,2'h0},
    '{7'h73,3'h0,5'h01,5'h01,64'h0,64'h0,64'h0,5'h00,2'h0},
    '{7'h5b,3'h0,5'h01,5'h02,64'h0,64'h0,64'h0,5'h00,2'h0},
    '{7'h20,3'h7,5'h01,5'h04,64'h40600000,64'h0,64'hffffffff40800000,5'h00,2'h1},
    '{7'h61,3'h7,5'h01,5'h08,64'h3ff0000000000000,64'h0,64'h0,5'h00,2'h0}};
  logic ref_clk = 1'b0, sys_rst = 1'b1, issueValid = 1'b0;
  logic [6:0] opcode = OPC_OP_FP, funct7 = 7'h00;
  logic [2:0] funct3 = 3'h0, frm = 3'h0;
  logic [4:0] rs1Idx = 5'h00, rs2Idx = 5'h00, rdIdx = 5'h00;
  logic [FPW-1:0] fpA = '0, fpB = '0, fpResult;
  logic [31:0] intA = 32'h0, intB = 32'h0, intResult;
  logic doneValid, fpWe, intWe, illegalInsn, ok;
  logic [4:0] rdOut, fflags, accrued;
  int fails = 0, checked = 0;
  fpx_row_t r;
  always #5 ref_clk = ~ref_clk;
  fpx_ops_unit DUT (.ref_clk, .sys_rst, .issueValid, .opcode, .funct7, .funct3, .rs1Idx,
    .rs2Idx, .rdIdx, .frm, .fpA, .fpB, .intA, .intB, .doneValid, .fpWe, .intWe, .rdOut,
    .fpResult, .intResult, .fflags, .illegalInsn);
  fpx_core_model CORE (.ref_clk, .sys_rst, .doneValid, .fpWe, .rdOut, .fpResult, .fflags,
    .accrued);
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One comparison; an unknown result never counts as a match
  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got, input logic good);
    checked++;
    if (good !== 1'b1) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Present one table row as an issue
  task drive(input int j);
    r = ROWS[j];
    issueValid = 1'b1;
    funct7 = r.f7;
    funct3 = r.f3;
    rs1Idx = r.s1;
    rs2Idx = r.s2;
    rdIdx = 5'(j);
    fpA = {{64{1'b1}}, r.a};
    fpB = {{64{1'b1}}, r.b};
    intA = r.a[31:0];
    intB = r.a[63:32];
  endtask
  // Result of row j, one cycle after it was taken
  task check_row(input int j);
    r = ROWS[j];
    ok = (r.w == 2'h0) ? (illegalInsn === 1'b1 && doneValid === 1'b0 && fflags === 5'h00)
      : (doneValid === 1'b1 && fflags === r.fl && rdOut === 5'(j) && ((r.w == 2'h1)
      ? (fpWe === 1'b1 && fpResult === {{64{1'b1}}, r.e})
      : (intWe === 1'b1 && intResult === r.e[31:0])));
    chk($sformatf("row%0d", j), r.e, fpWe ? fpResult[63:0] : {32'h0, intResult}, ok);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Back-to-back issues, then idle, mid-run reset and reissue
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i <= NR; i++) begin
      @(posedge ref_clk);
      #1;
      if (i > 0) check_row(i - 1);
      if (i == 10) chk("accrued", 64'h0, {59'h0, accrued}, accrued === 5'h00);
      if (i < NR) drive(i);
      else issueValid = 1'b0;
    end
    @(posedge ref_clk);
    #1;
    chk("idle", 64'h0, fpResult[63:0], doneValid === 1'b0 && fpResult === '0 && intResult === '0);
    chk("accrued", 64'h11, {59'h0, accrued}, accrued === 5'h11);
    chk("fpreg", ROWS[4].e, CORE.fpRegs[4][63:0],
      CORE.fpRegs[4] === {{64{1'b1}}, ROWS[4].e});
    drive(13);
    @(posedge ref_clk);
    #1 sys_rst = 1'b1;
    #1;
    chk("reset", 64'h0, fpResult[63:0], doneValid === 1'b0 && fpResult === '0 && fflags === '0);
    @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    drive(17);
    @(posedge ref_clk);
    #1;
    check_row(17);
    close_out();
  end
  // Cut a hang short; the whole run needs well under a microsecond
  initial begin
    #20000;
    fails++;
    close_out();
  end
endmodule
